// file: verilog/bfpg_consts.svh
// Constants of the buck fault and power-good logic.
`ifndef BFPG_CONSTS_SVH
`define BFPG_CONSTS_SVH
`define BFPG_CLK_MHZ           40
`define BFPG_DEGLITCH_NS       36000
`define BFPG_DEGLITCH_CYC      ((`BFPG_DEGLITCH_NS * `BFPG_CLK_MHZ + 999) / 1000)
`define BFPG_OC_CYCLES         128
`define BFPG_HICCUP_CYCLES     8192
`define BFPG_CLAMP_W           4
`define BFPG_CLAMP_MAX         4'hF
`define BFPG_SYNC_MIN_NS       50
`define BFPG_SYNC_MIN_CYC      ((`BFPG_SYNC_MIN_NS * `BFPG_CLK_MHZ + 999) / 1000)
`define BFPG_SRC_FET_UA        200
`define BFPG_SRC_SHUNT_UA      100
`define BFPG_SRC_FET_TC_PPM    4500
`define BFPG_DGL_W             11
`define BFPG_HIC_W             14
`endif

// file: verilog/bfpg_pkg.sv
// Types of the buck fault and power-good logic.
package bfpg_pkg;
	typedef enum logic [2:0] {
		BFPG_OFF,
		BFPG_DETECT,
		BFPG_RUN,
		BFPG_HICCUP,
		BFPG_THERMAL
	} bfpg_state_e;

	typedef struct packed {
		logic fb_above_94;
		logic fb_below_92;
		logic fb_above_108;
		logic fb_below_105;
	} bfpg_fb_s;

	typedef struct packed {
		logic valley_over;
		logic limit_below_gnd;
		logic comp_above_clamp;
		logic ramp_above_comp;
		logic over_temp;
		logic temp_below_restart;
		logic limit_program_pin_on_switch_node;
	} bfpg_afe_s;

	typedef struct packed {
		logic       high_side_on;
		logic       low_side_on;
		logic       soft_start_pull_low;
		logic       fet_resistance_sense_mode;
		logic [7:0] src_current_ua;
		logic       src_tc_enable;
	} bfpg_drive_s;
endpackage : bfpg_pkg

// file: verilog/bfpg_sync.sv
// Two-flop synchroniser for a vector of asynchronous inputs.
`timescale 1ns/1ps
module bfpg_sync #(
	parameter int W = 1
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst_b,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;
endmodule : bfpg_sync

// file: verilog/bfpg_deglitch.sv
// Restartable deglitch timer: output rises after the input holds for the full interval.
`timescale 1ns/1ps
`include "bfpg_consts.svh"
module bfpg_deglitch (
	input  wire logic i_sys_clk,
	input  wire logic i_rst_b,
	input  wire logic i_cond,
	output logic      o_done
);
	import bfpg_pkg::*;

	typedef struct packed {
		logic [`BFPG_DGL_W-1:0] cnt;
		logic                   done;
	} bfpg_dgl_s;

	localparam logic [`BFPG_DGL_W-1:0] DGL_LAST = `BFPG_DGL_W'(`BFPG_DEGLITCH_CYC - 1);

	bfpg_dgl_s st_r;
	bfpg_dgl_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (!i_cond) begin
			st_nxt.cnt  = '0;
			st_nxt.done = 1'b0;
		end else if (st_r.cnt == DGL_LAST) begin
			st_nxt.done = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_done = st_r.done;
endmodule : bfpg_deglitch

// file: verilog/bfpg_top.sv
// Fault protection and power-good supervision of a synchronous buck controller.
`timescale 1ns/1ps
`include "bfpg_consts.svh"
module bfpg_top (
	input  wire logic                i_sys_clk,
	input  wire logic                i_rst_b,
	input  wire logic                i_osc_clk,
	input  wire logic                i_sync_clock_input,
	input  wire logic                i_sync_select,
	input  wire logic                i_enable_above_thr,
	input  wire logic                i_supply_above_uvlo,
	input  wire bfpg_pkg::bfpg_fb_s  i_fb,
	input  wire bfpg_pkg::bfpg_afe_s i_afe,
	output bfpg_pkg::bfpg_drive_s    o_drive,
	output logic [`BFPG_CLAMP_W-1:0] o_clamp_level,
	output logic                     o_power_good_output_o,
	output logic                     o_power_good_output_oe,
	output logic                     o_hiccup_active,
	output logic                     o_thermal_shutdown,
	output logic                     o_sync_locked
);
	import bfpg_pkg::*;

	// ************************************************************
	// Input synchronisation
	// ************************************************************
	// Every pin, the select strap included, passes the same two flops; the width must
	// equal the sum of the pin widths that are packed into raw_in below.
	localparam int SYN_W = 16;

	logic [SYN_W-1:0] raw_in;
	logic [SYN_W-1:0] syn_in;
	bfpg_fb_s         fb;
	bfpg_afe_s        afe;
	logic             osc_s;
	logic             sync_s;
	logic             sel_s;
	logic             en_s;
	logic             uv_s;
	logic             dg_pg_up;
	logic             dg_pg_low;
	logic             dg_pg_ov;

	assign raw_in = {i_osc_clk, i_sync_clock_input, i_sync_select, i_enable_above_thr,
		i_supply_above_uvlo, i_fb, i_afe};

	bfpg_sync #(.W(SYN_W)) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_rst_b   (i_rst_b),
		.i_async   (raw_in),
		.o_sync    (syn_in)
	);

	assign {osc_s, sync_s, sel_s, en_s, uv_s, fb, afe} = syn_in;

	// ************************************************************
	// Power-good deglitch timers
	// ************************************************************
	// Each timer starts over when its condition drops, so separate glitches never add up.
	bfpg_deglitch u_dg_up (
		.i_sys_clk (i_sys_clk),
		.i_rst_b   (i_rst_b),
		.i_cond    (fb.fb_above_94 && !fb.fb_above_108),
		.o_done    (dg_pg_up)
	);

	bfpg_deglitch u_dg_low (
		.i_sys_clk (i_sys_clk),
		.i_rst_b   (i_rst_b),
		.i_cond    (fb.fb_below_92),
		.o_done    (dg_pg_low)
	);

	bfpg_deglitch u_dg_ov (
		.i_sys_clk (i_sys_clk),
		.i_rst_b   (i_rst_b),
		.i_cond    (fb.fb_above_108),
		.o_done    (dg_pg_ov)
	);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		bfpg_state_e              state;
		logic                     clk_d;
		logic                     sync_d;
		logic                     fet_mode;
		logic                     hs_on;
		logic                     ls_on;
		logic                     oc_seen;
		logic                     valley_d;
		logic [7:0]               oc_cnt;
		logic [`BFPG_HIC_W-1:0]   hic_cnt;
		logic [`BFPG_CLAMP_W-1:0] clamp;
		logic                     pg;
		logic                     ov_latched;
		logic [3:0]               sync_hi;
		logic                     sync_ok;
		logic                     tsd;
	} bfpg_top_s;

	localparam logic [7:0]               OC_LAST  = 8'(`BFPG_OC_CYCLES - 1);
	localparam logic [`BFPG_HIC_W-1:0]   HIC_LAST = `BFPG_HIC_W'(`BFPG_HICCUP_CYCLES - 1);
	localparam logic [3:0]               SYNC_MIN = 4'(`BFPG_SYNC_MIN_CYC);
	localparam logic [`BFPG_CLAMP_W-1:0] CLAMP_TOP = `BFPG_CLAMP_MAX;

	bfpg_top_s st_r;
	bfpg_top_s st_nxt;

	logic period_start;
	logic active;
	logic pulse_block;

	always_comb begin
		st_nxt       = st_r;
		active       = en_s && uv_s;
		period_start = 1'b0;
		pulse_block  = 1'b0;

		st_nxt.clk_d    = osc_s;
		st_nxt.sync_d   = sync_s;
		st_nxt.valley_d = afe.valley_over;

		// A sync pulse shorter than the minimum width clears the lock; its own falling edge still starts a period if the lock was held.
		if (sync_s) begin
			if (st_r.sync_hi != 4'hF) begin
				st_nxt.sync_hi = st_r.sync_hi + 4'h1;
			end
		end else begin
			st_nxt.sync_hi = 4'h0;
		end
		if (st_r.sync_d && !sync_s) begin
			st_nxt.sync_ok = (st_r.sync_hi >= SYNC_MIN);
		end

		// The frequency-window check on the sync clock is the board's duty; this logic
		// only follows whichever edge source is chosen.
		// The select strap is synchronised as well, so a change acts two cycles late.
		if (sel_s && st_r.sync_ok) begin
			period_start = st_r.sync_d && !sync_s;
		end else begin
			period_start = st_r.clk_d && !osc_s;
		end

		pulse_block = afe.limit_below_gnd || afe.valley_over;

		case (st_r.state)
			BFPG_OFF: begin
				st_nxt.hs_on = 1'b0;
				st_nxt.ls_on = 1'b0;
				if (active) begin
					st_nxt.state = BFPG_DETECT;
				end
			end
			BFPG_DETECT: begin
				st_nxt.fet_mode = afe.limit_program_pin_on_switch_node;
				st_nxt.clamp    = CLAMP_TOP;
				st_nxt.oc_cnt   = '0;
				st_nxt.oc_seen  = 1'b0;
				st_nxt.state    = BFPG_RUN;
			end
			BFPG_RUN: begin
				if (afe.valley_over && !st_r.valley_d && st_r.clamp != '0) begin
					st_nxt.clamp = st_r.clamp - 1'b1;
				end
				if (afe.valley_over || afe.limit_below_gnd) begin
					st_nxt.oc_seen = 1'b1;
				end
				if (period_start) begin
					if (st_r.oc_seen || afe.valley_over) begin
						if (st_r.oc_cnt == OC_LAST) begin
							st_nxt.state   = BFPG_HICCUP;
							st_nxt.hic_cnt = '0;
						end else begin
							st_nxt.oc_cnt = st_r.oc_cnt + 8'h01;
						end
					end else begin
						st_nxt.oc_cnt = '0;
						if (st_r.clamp != CLAMP_TOP) begin
							st_nxt.clamp = st_r.clamp + 1'b1;
						end
					end
					st_nxt.oc_seen = 1'b0;
					st_nxt.hs_on   = !pulse_block;
					st_nxt.ls_on   = pulse_block;
				end else if (st_r.hs_on) begin
					if (afe.ramp_above_comp || afe.comp_above_clamp || pulse_block) begin
						st_nxt.hs_on = 1'b0;
						st_nxt.ls_on = 1'b1;
					end
				end
			end
			BFPG_HICCUP: begin
				st_nxt.hs_on = 1'b0;
				st_nxt.ls_on = 1'b0;
				if (period_start) begin
					if (st_r.hic_cnt == HIC_LAST) begin
						st_nxt.state = BFPG_DETECT;
					end else begin
						st_nxt.hic_cnt = st_r.hic_cnt + 1'b1;
					end
				end
			end
			BFPG_THERMAL: begin
				st_nxt.hs_on = 1'b0;
				st_nxt.ls_on = 1'b0;
				if (afe.temp_below_restart) begin
					st_nxt.state = BFPG_OFF;
				end
			end
			default: begin
				st_nxt.state = BFPG_OFF;
			end
		endcase

		if (afe.over_temp) begin
			st_nxt.tsd   = 1'b1;
			st_nxt.state = BFPG_THERMAL;
			st_nxt.hs_on = 1'b0;
			st_nxt.ls_on = 1'b0;
		end else if (st_r.state == BFPG_THERMAL && afe.temp_below_restart) begin
			st_nxt.tsd = 1'b0;
		end

		if (!active && st_r.state != BFPG_THERMAL) begin
			st_nxt.state = BFPG_OFF;
			st_nxt.hs_on = 1'b0;
			st_nxt.ls_on = 1'b0;
		end

		// Power-good: faults win over the good qualifier.
		if (dg_pg_ov) begin
			st_nxt.pg         = 1'b0;
			st_nxt.ov_latched = 1'b1;
		end else if (st_r.ov_latched) begin
			if (fb.fb_below_105) begin
				st_nxt.pg         = 1'b1;
				st_nxt.ov_latched = 1'b0;
			end
		end else if (dg_pg_low) begin
			st_nxt.pg = 1'b0;
		end else if (dg_pg_up) begin
			st_nxt.pg = 1'b1;
		end
		// Leaving the run state drops power-good at once; no deglitch delays a fault.
		if (st_nxt.state != BFPG_RUN) begin
			st_nxt.pg = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	always_comb begin
		o_drive.high_side_on              = st_r.hs_on;
		o_drive.low_side_on               = st_r.ls_on;
		o_drive.soft_start_pull_low       = (st_r.state != BFPG_RUN);
		o_drive.fet_resistance_sense_mode = st_r.fet_mode;
		o_drive.src_current_ua = st_r.fet_mode ? 8'(`BFPG_SRC_FET_UA)
			: 8'(`BFPG_SRC_SHUNT_UA);
		o_drive.src_tc_enable  = st_r.fet_mode;
	end

	assign o_clamp_level          = st_r.clamp;
	assign o_power_good_output_o  = 1'b0;
	assign o_power_good_output_oe = !st_r.pg;
	assign o_hiccup_active        = (st_r.state == BFPG_HICCUP);
	assign o_thermal_shutdown     = st_r.tsd;
	assign o_sync_locked          = st_r.sync_ok;
endmodule : bfpg_top

// file: tb/bfpg_partner.sv
// Model of the power stage, sense network, die temperature and sync clock.
`timescale 1ns/1ps
module bfpg_partner (
	input  wire logic [7:0]      i_temp_c,
	input  wire logic [4:0]      i_knob,
	output bfpg_pkg::bfpg_afe_s  o_afe,
	output logic                 o_sync_clk
);
	import bfpg_pkg::*;
	// The gap between the two thresholds is the thermal hysteresis band.
	assign o_afe.over_temp = i_temp_c > 8'hAF;
	assign o_afe.temp_below_restart = i_temp_c < 8'h9B;
	assign o_afe.valley_over = i_knob[0];
	assign o_afe.limit_below_gnd = i_knob[1];
	assign o_afe.comp_above_clamp = i_knob[2];
	assign o_afe.ramp_above_comp = i_knob[3];
	assign o_afe.limit_program_pin_on_switch_node = i_knob[4];
	initial begin
		o_sync_clk = 1'h0;
		forever #500 o_sync_clk = ~o_sync_clk;
	end
endmodule : bfpg_partner

// file: tb/bfpg_chk.sv
// Concurrent checks on the ports of the buck fault and power-good logic.
`timescale 1ns/1ps
`include "bfpg_consts.svh"
module bfpg_chk (
	input wire logic                     i_sys_clk,
	input wire logic                     i_rst_b,
	input wire logic                     i_enable_above_thr,
	input wire bfpg_pkg::bfpg_fb_s       i_fb,
	input wire bfpg_pkg::bfpg_afe_s      i_afe,
	input wire bfpg_pkg::bfpg_drive_s    o_drive,
	input wire logic                     o_power_good_output_o,
	input wire logic                     o_power_good_output_oe,
	input wire logic                     o_hiccup_active,
	input wire logic                     o_thermal_shutdown
);
	import bfpg_pkg::*;
	logic [11:0] c94, c92, c108;
	logic        ovh;
	function automatic logic [11:0] inc(input logic [11:0] v);
		return (v == 12'hFFF) ? v : v + 12'h001;
	endfunction : inc
	// Run lengths of raw inputs; the design adds its synchroniser delay.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			c94 <= 12'h000;
			c92 <= 12'h000;
			c108 <= 12'h000;
			ovh <= 1'h0;
		end else begin
			c94 <= (i_fb.fb_above_94 && !i_fb.fb_above_108) ? inc(c94) : 12'h000;
			c92 <= i_fb.fb_below_92 ? inc(c92) : 12'h000;
			c108 <= i_fb.fb_above_108 ? inc(c108) : 12'h000;
			ovh <= ovh || (c108 >= 12'h5A0);
		end
	end
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_b);
	property p_pg_drv; o_power_good_output_o == 1'h0; endproperty
	a_pg_drv: assert property (p_pg_drv) else $error("pg drives high");
	property p_pg_rise; $fell(o_power_good_output_oe) |-> c94 >= 12'h5A0 || ovh; endproperty
	a_pg_rise: assert property (p_pg_rise) else $error("pg rose early");
	property p_pg_uv; c92 >= 12'h5AA |-> o_power_good_output_oe; endproperty
	a_pg_uv: assert property (p_pg_uv) else $error("pg high under 92");
	property p_pg_ov; c108 >= 12'h5AA |-> o_power_good_output_oe; endproperty
	a_pg_ov: assert property (p_pg_ov) else $error("pg high over 108");
	property p_tsd; o_thermal_shutdown [*2] |-> !o_drive.high_side_on &&
		!o_drive.low_side_on && o_drive.soft_start_pull_low && o_power_good_output_oe; endproperty
	a_tsd: assert property (p_tsd) else $error("not off in shutdown");
	property p_tsd_hold; (o_thermal_shutdown && !i_afe.temp_below_restart) [*4] |=>
		o_thermal_shutdown; endproperty
	a_tsd_hold: assert property (p_tsd_hold) else $error("early restart");
	property p_hic; o_hiccup_active [*2] |-> o_drive.soft_start_pull_low &&
		!o_drive.high_side_on; endproperty
	a_hic: assert property (p_hic) else $error("hiccup not holding");
	property p_valley; i_afe.valley_over [*5] |=> !$rose(o_drive.high_side_on); endproperty
	a_valley: assert property (p_valley) else $error("on above valley");
	property p_gnd; i_afe.limit_below_gnd [*5] |=> !$rose(o_drive.high_side_on); endproperty
	a_gnd: assert property (p_gnd) else $error("pulse below ground");
	property p_clamp; i_afe.comp_above_clamp [*4] ##0 o_drive.high_side_on |->
		##[1:3] !o_drive.high_side_on; endproperty
	a_clamp: assert property (p_clamp) else $error("on-time not cut");
	property p_src; o_drive.src_current_ua == (o_drive.fet_resistance_sense_mode ?
		8'hC8 : 8'h64) && o_drive.src_tc_enable == o_drive.fet_resistance_sense_mode; endproperty
	a_src: assert property (p_src) else $error("bad source setting");
	property p_off; !i_enable_above_thr [*5] |=> o_drive.soft_start_pull_low &&
		!o_drive.high_side_on && o_power_good_output_oe; endproperty
	a_off: assert property (p_off) else $error("active while disabled");
	c_hic: cover property ($rose(o_hiccup_active));
	c_tsd: cover property ($rose(o_thermal_shutdown));
	c_pg: cover property ($fell(o_power_good_output_oe));
endmodule : bfpg_chk

// file: tb/tb_top.sv
// Self-checking bench of the buck fault and power-good logic.
`timescale 1ns/1ps
`include "bfpg_consts.svh"
module tb_top;
	import bfpg_pkg::*;
	logic                     i_sys_clk, i_rst_b, i_osc_clk, en, sup, sclk;
	logic                     pg_o, pg_oe, hic, tsd, ssel, slock;
	logic [7:0]               temp;
	logic [4:0]               knob;
	logic [`BFPG_CLAMP_W-1:0] clamp;
	bfpg_fb_s                 fb;
	bfpg_afe_s                afe;
	bfpg_drive_s              drv;
	int                       failures, checks;
	bfpg_top i_bfpg_top (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_osc_clk(i_osc_clk),
		.i_sync_clock_input(sclk), .i_sync_select(ssel), .i_enable_above_thr(en),
		.i_supply_above_uvlo(sup), .i_fb(fb), .i_afe(afe), .o_drive(drv),
		.o_clamp_level(clamp), .o_power_good_output_o(pg_o), .o_power_good_output_oe(pg_oe),
		.o_hiccup_active(hic), .o_thermal_shutdown(tsd), .o_sync_locked(slock));
	bfpg_partner i_bfpg_partner (.i_temp_c(temp), .i_knob(knob), .o_afe(afe), .o_sync_clk(sclk));
	initial begin
		i_sys_clk = 1'h0;
		forever #12.5 i_sys_clk = ~i_sys_clk;
	end
	// A six-cycle switching period keeps the 8192-period hiccup affordable.
	initial begin
		i_osc_clk = 1'h0;
		forever begin
			cyc(3);
			i_osc_clk = ~i_osc_clk;
		end
	end
	initial begin
		#2000000;
		failures++;
		$display("unexpected at %0t: run timed out", $time);
		finish_test();
	end
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic cyc(input int n);
		repeat (n) begin
			@(posedge i_sys_clk);
			#1;
		end
	endtask : cyc
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	task automatic wait_st(input logic sel, input logic v, input int n);
		int k;
		for (k = 0; k < n; k++) begin
			if ((sel ? tsd : hic) === v) break;
			cyc(1);
		end
		if (k == n) begin
			failures++;
			$display("unexpected at %0t: state flag never reached", $time);
			finish_test();
		end
	endtask : wait_st
	// Counts the sampled cycles in which the high side is on.
	task automatic seen_hs(input int n, output int c);
		c = 0;
		repeat (n) begin
			cyc(1);
			if (drv.high_side_on === 1'b1) c++;
		end
	endtask : seen_hs
	task automatic t_start();
		int c;
		chk(drv.soft_start_pull_low, 8'h01);
		chk(drv.src_current_ua, 8'h64);
		en = 1'h1;
		sup = 1'h1;
		seen_hs(40, c);
		chk(c != 0, 8'h01);
		chk(drv.src_current_ua, 8'hC8);
		chk(drv.src_tc_enable, 8'h01);
		chk(drv.soft_start_pull_low, 8'h00);
	endtask : t_start
	task automatic t_pg();
		fb = 4'h9;
		cyc(1000);
		fb = 4'h5;
		cyc(20);
		fb = 4'h9;
		cyc(1400);
		chk(pg_oe, 8'h01);
		cyc(100);
		chk(pg_oe, 8'h00);
		fb = 4'h5;
		cyc(1400);
		chk(pg_oe, 8'h00);
		cyc(100);
		chk(pg_oe, 8'h01);
		fb = 4'h9;
		cyc(1500);
		fb = 4'hA;
		cyc(1400);
		chk(pg_oe, 8'h00);
		cyc(100);
		chk(pg_oe, 8'h01);
		fb = 4'h9;
		cyc(10);
		chk(pg_oe, 8'h00);
		chk(pg_o, 8'h00);
	endtask : t_pg
	task automatic t_ocp();
		chk(clamp, 8'h0F);
		knob[0] = 1'h1;
		cyc(12);
		chk(clamp, 8'h0E);
		chk(drv.high_side_on, 8'h00);
		cyc(600);
		knob[0] = 1'h0;
		cyc(18);
		knob[0] = 1'h1;
		cyc(720);
		chk(hic, 8'h00);
		cyc(96);
		chk(hic, 8'h01);
		knob[0] = 1'h0;
		cyc(48600);
		chk(drv.soft_start_pull_low, 8'h01);
		wait_st(1'h0, 1'h0, 1800);
		cyc(12);
		chk(drv.soft_start_pull_low, 8'h00);
	endtask : t_ocp
	task automatic t_limits();
		int c;
		// The flag needs two cycles through the synchroniser before it can cut a pulse.
		for (int b = 1; b < 4; b++) begin
			knob[b] = 1'h1;
			cyc(3);
			seen_hs(60, c);
			if (b == 1) chk(c == 0, 8'h01);
			else chk(c < 20, 8'h01);
			knob[b] = 1'h0;
			cyc(18);
		end
		// With the on-time cut to one cycle, the pulse count shows which clock starts periods.
		knob[2] = 1'h1;
		ssel = 1'h1;
		cyc(3);
		seen_hs(120, c);
		chk(c >= 2 && c <= 4, 8'h01);
		chk(slock, 8'h01);
		knob[2] = 1'h0;
		ssel = 1'h0;
		cyc(18);
	endtask : t_limits
	task automatic t_therm();
		temp = 8'hB4;
		wait_st(1'h1, 1'h1, 40);
		cyc(2);
		chk({drv.high_side_on, drv.low_side_on, drv.soft_start_pull_low, pg_oe}, 8'h03);
		temp = 8'hA5;
		cyc(50);
		chk(tsd, 8'h01);
		temp = 8'h8C;
		wait_st(1'h1, 1'h0, 40);
		cyc(10);
		chk(drv.soft_start_pull_low, 8'h00);
		en = 1'h0;
		cyc(8);
		chk({drv.high_side_on, drv.soft_start_pull_low, pg_oe}, 8'h03);
	endtask : t_therm
	initial begin
		failures = 0;
		checks = 0;
		i_rst_b = 1'h0;
		en = 1'h0;
		sup = 1'h0;
		ssel = 1'h0;
		fb = 4'h5;
		knob = 5'h10;
		temp = 8'h19;
		cyc(20);
		i_rst_b = 1'h1;
		cyc(2);
		t_start();
		t_pg();
		t_ocp();
		t_limits();
		t_therm();
		finish_test();
	end
endmodule : tb_top
bind bfpg_top bfpg_chk i_bfpg_chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
	.i_enable_above_thr(i_enable_above_thr), .i_fb(i_fb), .i_afe(i_afe), .o_drive(o_drive),
	.o_power_good_output_o(o_power_good_output_o),
	.o_power_good_output_oe(o_power_good_output_oe),
	.o_hiccup_active(o_hiccup_active), .o_thermal_shutdown(o_thermal_shutdown));
